// *** core/iws_params.svh ***
// constants for the i2c master write sequencer
// assumes a 50 MHz host clock and a free-running link clock
`ifndef IWS_PARAMS_SVH
`define IWS_PARAMS_SVH
`define IWS_CNT_W          32
`define IWS_ADDR_W         7
`define IWS_DIR_WRITE      1'b0
`define IWS_FIFO_DEPTH     2
`define IWS_HOST_PERIOD_NS 20
`define IWS_LINK_PERIOD_NS 64
`define IWS_SCL_PERIOD_NS  2500
`define IWS_QTR_CYC ((`IWS_SCL_PERIOD_NS / 4 + `IWS_LINK_PERIOD_NS - 1) / `IWS_LINK_PERIOD_NS)
`endif

// *** core/iws_pkg.sv ***
// types shared by the i2c master write sequencer
// assumes iws_params.svh on the include path
`include "iws_params.svh"
package iws_pkg;
  typedef enum logic [2:0] {
    IWS_RES_OK       = 3'h0,
    IWS_RES_INVALID  = 3'h1,
    IWS_RES_BUS_BUSY = 3'h2,
    IWS_RES_ARB_LOST = 3'h3,
    IWS_RES_NACK     = 3'h4
  } iws_result_t;
  typedef struct packed {
    logic                    addr_present;
    logic [`IWS_ADDR_W-1:0]  slave_addr;
    logic [`IWS_CNT_W-1:0]   first_block_byte_count;
    logic [`IWS_CNT_W-1:0]   second_block_byte_count;
  } iws_req_t;
  typedef struct packed {
    logic        done;
    iws_result_t result;
  } iws_resp_t;
  typedef enum logic [1:0] {
    IWS_H_IDLE = 2'b01,
    IWS_H_BUSY = 2'b10
  } iws_hstate_t;
  typedef enum logic [6:0] {
    IWS_L_IDLE  = 7'b0000001,
    IWS_L_START = 7'b0000010,
    IWS_L_BIT   = 7'b0000100,
    IWS_L_ACK   = 7'b0001000,
    IWS_L_FETCH = 7'b0010000,
    IWS_L_STOP  = 7'b0100000,
    IWS_L_DONE  = 7'b1000000
  } iws_lstate_t;
endpackage

// *** core/iws_seq.sv ***
// i2c master write sequencer: host side request, byte buffer, bus engine
// assumes open-drain scl/sda resolved outside; link_clk runs free
`timescale 1ns/1ps
`default_nettype none
`include "iws_params.svh"
module iws_seq (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire iws_pkg::iws_req_t req,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [7:0]        wr_data,
  input  wire logic              wr_valid,
  output logic                   wr_ready,
  output iws_pkg::iws_resp_t     resp,
  output logic                   busy,
  input  wire logic              link_clk,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe_n,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n
);
  // ==========================================================
  // functions
  function automatic logic pattern_ok(input iws_pkg::iws_req_t r);
    logic c1;
    logic c2;
    c1 = (r.first_block_byte_count != '0);
    c2 = (r.second_block_byte_count != '0);
    pattern_ok = r.addr_present ? (!c1 || c2) : (!c1 && !c2);
  endfunction
  function automatic logic [`IWS_CNT_W-1:0] dec(input logic [`IWS_CNT_W-1:0] v);
    dec = v - `IWS_CNT_W'(1);
  endfunction

  // ==========================================================
  // host domain declarations
  iws_pkg::iws_hstate_t  hst_reg, hst_next;
  iws_pkg::iws_req_t     cmd_reg, cmd_next;
  iws_pkg::iws_result_t  res_reg, res_next;
  logic                  done_reg, done_next;
  logic                  cmd_tgl_reg, cmd_tgl_next;
  logic                  back_tgl_reg, back_tgl_next;
  logic                  pend_reg, pend_next;
  logic [7:0]            bdat_reg, bdat_next;
  logic [7:0]            fmem_reg [`IWS_FIFO_DEPTH];
  logic [7:0]            fmem_next [`IWS_FIFO_DEPTH];
  logic                  fw_reg, fw_next, fr_reg, fr_next;
  logic [1:0]            fc_reg, fc_next;
  logic                  push, pop, flush;
  logic                  breq_s1, breq_s2, breq_s3, breq_edge;
  logic                  dtgl_s1, dtgl_s2, dtgl_s3, done_edge;
  // link domain declarations
  iws_pkg::iws_lstate_t  lst_reg, lst_next;
  iws_pkg::iws_result_t  lres_reg, lres_next;
  logic [1:0]            ph_reg, ph_next;
  logic [3:0]            qcnt_reg, qcnt_next;
  logic [2:0]            bit_reg, bit_next;
  logic [7:0]            sh_reg, sh_next;
  logic                  isaddr_reg, isaddr_next;
  logic                  haddr_reg, haddr_next;
  logic                  nack_reg, nack_next;
  logic [`IWS_CNT_W-1:0] rem1_reg, rem1_next, rem2_reg, rem2_next;
  logic                  scl_rel_reg, scl_rel_next, sda_rel_reg, sda_rel_next;
  logic                  dtgl_reg, dtgl_next, breq_reg, breq_next;
  logic                  lrst_s1, lrst_n;
  logic                  ctgl_s1, ctgl_s2, ctgl_s3, cmd_edge;
  logic                  btgl_s1, btgl_s2, btgl_s3, back_edge;
  logic                  en_s1, en_s2, scl_s1, scl_s, sda_s1, sda_s;
  logic                  tick, active;

  // ==========================================================
  // host request and byte service
  assign req_ready = clk_en && (hst_reg == iws_pkg::IWS_H_IDLE);
  assign busy      = (hst_reg == iws_pkg::IWS_H_BUSY);
  assign breq_edge = breq_s2 ^ breq_s3;
  assign done_edge = dtgl_s2 ^ dtgl_s3;
  assign resp      = '{done: done_reg, result: res_reg};

  always_comb begin
    hst_next      = hst_reg;
    cmd_next      = cmd_reg;
    res_next      = res_reg;
    done_next     = 1'b0;
    cmd_tgl_next  = cmd_tgl_reg;
    back_tgl_next = back_tgl_reg;
    pend_next     = pend_reg;
    bdat_next     = bdat_reg;
    pop           = 1'b0;
    flush         = 1'b0;
    unique case (hst_reg)
      iws_pkg::IWS_H_IDLE: begin
        if (req_valid) begin
          if (!pattern_ok(req)) begin
            done_next = 1'b1;
            res_next  = iws_pkg::IWS_RES_INVALID;
          end else begin
            cmd_next     = req;
            cmd_tgl_next = ~cmd_tgl_reg;
            hst_next     = iws_pkg::IWS_H_BUSY;
          end
        end
      end
      iws_pkg::IWS_H_BUSY: begin
        if (breq_edge) begin
          pend_next = 1'b1;
        end
        if (pend_reg && fc_reg != 2'h0) begin
          pop           = 1'b1;
          bdat_next     = fmem_reg[fr_reg];
          back_tgl_next = ~back_tgl_reg;
          pend_next     = breq_edge;
        end
        if (done_edge) begin
          done_next = 1'b1;
          res_next  = lres_reg;
          hst_next  = iws_pkg::IWS_H_IDLE;
          pend_next = 1'b0;
          flush     = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hst_reg      <= iws_pkg::IWS_H_IDLE;
      cmd_reg      <= '0;
      res_reg      <= iws_pkg::IWS_RES_OK;
      done_reg     <= 1'b0;
      cmd_tgl_reg  <= 1'b0;
      back_tgl_reg <= 1'b0;
      pend_reg     <= 1'b0;
      bdat_reg     <= 8'h00;
    end else if (clk_en) begin
      hst_reg      <= hst_next;
      cmd_reg      <= cmd_next;
      res_reg      <= res_next;
      done_reg     <= done_next;
      cmd_tgl_reg  <= cmd_tgl_next;
      back_tgl_reg <= back_tgl_next;
      pend_reg     <= pend_next;
      bdat_reg     <= bdat_next;
    end
  end

  // ==========================================================
  // two-entry byte buffer
  assign wr_ready = clk_en && (fc_reg != 2'(`IWS_FIFO_DEPTH)) && !done_edge;
  assign push     = wr_valid && wr_ready;

  always_comb begin
    fmem_next = fmem_reg;
    fw_next   = fw_reg;
    fr_next   = fr_reg;
    fc_next   = fc_reg;
    if (flush) begin
      fw_next = 1'b0;
      fr_next = 1'b0;
      fc_next = 2'h0;
    end else begin
      if (push) begin
        fmem_next[fw_reg] = wr_data;
        fw_next           = ~fw_reg;
      end
      if (pop) begin
        fr_next = ~fr_reg;
      end
      fc_next = 2'(fc_reg + {1'b0, push} - {1'b0, pop});
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fmem_reg <= '{default: 8'h00};
      fw_reg   <= 1'b0;
      fr_reg   <= 1'b0;
      fc_reg   <= 2'h0;
    end else if (clk_en) begin
      fmem_reg <= fmem_next;
      fw_reg   <= fw_next;
      fr_reg   <= fr_next;
      fc_reg   <= fc_next;
    end
  end

  // ==========================================================
  // host side synchronisers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {breq_s1, breq_s2, breq_s3} <= 3'h0;
      {dtgl_s1, dtgl_s2, dtgl_s3} <= 3'h0;
    end else begin
      {breq_s1, breq_s2} <= {breq_reg, breq_s1};
      {dtgl_s1, dtgl_s2} <= {dtgl_reg, dtgl_s1};
      if (clk_en) begin
        breq_s3 <= breq_s2;
        dtgl_s3 <= dtgl_s2;
      end
    end
  end

  // ==========================================================
  // link side synchronisers
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      {lrst_s1, lrst_n} <= 2'h0;
      {ctgl_s1, ctgl_s2} <= 2'h0;
      {btgl_s1, btgl_s2} <= 2'h0;
      {en_s1, en_s2}     <= 2'h0;
      {scl_s1, scl_s}    <= 2'h3;
      {sda_s1, sda_s}    <= 2'h3;
    end else begin
      {lrst_s1, lrst_n}  <= {1'b1, lrst_s1};
      {ctgl_s1, ctgl_s2} <= {cmd_tgl_reg, ctgl_s1};
      {btgl_s1, btgl_s2} <= {back_tgl_reg, btgl_s1};
      {en_s1, en_s2}     <= {clk_en, en_s1};
      {scl_s1, scl_s}    <= {scl_i, scl_s1};
      {sda_s1, sda_s}    <= {sda_i, sda_s1};
    end
  end

  // ==========================================================
  // bus engine
  assign cmd_edge  = ctgl_s2 ^ ctgl_s3;
  assign back_edge = btgl_s2 ^ btgl_s3;
  assign active    = (lst_reg == iws_pkg::IWS_L_START) ||
                     (lst_reg == iws_pkg::IWS_L_BIT) ||
                     (lst_reg == iws_pkg::IWS_L_ACK) ||
                     (lst_reg == iws_pkg::IWS_L_STOP);
  assign tick      = active && (qcnt_reg == 4'(`IWS_QTR_CYC - 1));
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;
  assign scl_oe_n  = scl_rel_reg;
  assign sda_oe_n  = sda_rel_reg;

  always_comb begin
    lst_next     = lst_reg;
    lres_next    = lres_reg;
    ph_next      = tick ? 2'(ph_reg + 2'h1) : ph_reg;
    qcnt_next    = (!active || tick) ? 4'h0 : 4'(qcnt_reg + 4'h1);
    bit_next     = bit_reg;
    sh_next      = sh_reg;
    isaddr_next  = isaddr_reg;
    haddr_next   = haddr_reg;
    nack_next    = nack_reg;
    rem1_next    = rem1_reg;
    rem2_next    = rem2_reg;
    scl_rel_next = scl_rel_reg;
    sda_rel_next = sda_rel_reg;
    dtgl_next    = dtgl_reg;
    breq_next    = breq_reg;
    unique case (lst_reg)
      iws_pkg::IWS_L_IDLE: begin
        scl_rel_next = 1'b1;
        sda_rel_next = 1'b1;
        ph_next      = 2'h0;
        if (cmd_edge) begin
          rem1_next  = cmd_reg.first_block_byte_count;
          rem2_next  = cmd_reg.second_block_byte_count;
          haddr_next = cmd_reg.addr_present;
          if (!(scl_s && sda_s)) begin
            lres_next = iws_pkg::IWS_RES_BUS_BUSY;
            lst_next  = iws_pkg::IWS_L_DONE;
          end else begin
            lres_next = iws_pkg::IWS_RES_OK;
            lst_next  = iws_pkg::IWS_L_START;
          end
        end
      end
      iws_pkg::IWS_L_START: begin
        if (tick) begin
          unique case (ph_reg)
            2'h0: sda_rel_next = 1'b0;
            2'h1: scl_rel_next = 1'b0;
            2'h2: ;
            2'h3: begin
              if (haddr_reg) begin
                sh_next     = {cmd_reg.slave_addr, `IWS_DIR_WRITE};
                isaddr_next = 1'b1;
                bit_next    = 3'h0;
                lst_next    = iws_pkg::IWS_L_BIT;
              end else begin
                lst_next = iws_pkg::IWS_L_STOP;
              end
            end
          endcase
        end
      end
      iws_pkg::IWS_L_BIT: begin
        if (tick) begin
          unique case (ph_reg)
            2'h0: sda_rel_next = sh_reg[7];
            2'h1: scl_rel_next = 1'b1;
            2'h2: begin
              if (sda_rel_reg && !sda_s) begin
                lres_next    = iws_pkg::IWS_RES_ARB_LOST;
                scl_rel_next = 1'b1;
                lst_next     = iws_pkg::IWS_L_DONE;
              end
            end
            2'h3: begin
              scl_rel_next = 1'b0;
              sh_next      = {sh_reg[6:0], 1'b0};
              bit_next     = 3'(bit_reg + 3'h1);
              if (bit_reg == 3'h7) begin
                lst_next = iws_pkg::IWS_L_ACK;
              end
            end
          endcase
        end
      end
      iws_pkg::IWS_L_ACK: begin
        if (tick) begin
          unique case (ph_reg)
            2'h0: sda_rel_next = 1'b1;
            2'h1: scl_rel_next = 1'b1;
            2'h2: nack_next = sda_s;
            2'h3: begin
              scl_rel_next = 1'b0;
              isaddr_next  = 1'b0;
              if (nack_reg) begin
                lres_next = iws_pkg::IWS_RES_NACK;
                lst_next  = iws_pkg::IWS_L_STOP;
              end else if (rem1_reg != '0 || rem2_reg != '0) begin
                breq_next = ~breq_reg;
                lst_next  = iws_pkg::IWS_L_FETCH;
              end else begin
                lst_next = iws_pkg::IWS_L_STOP;
              end
            end
          endcase
        end
      end
      iws_pkg::IWS_L_FETCH: begin
        if (back_edge) begin
          sh_next  = bdat_reg;
          bit_next = 3'h0;
          lst_next = iws_pkg::IWS_L_BIT;
          if (rem1_reg != '0) begin
            rem1_next = dec(rem1_reg);
          end else begin
            rem2_next = dec(rem2_reg);
          end
        end
      end
      iws_pkg::IWS_L_STOP: begin
        if (tick) begin
          unique case (ph_reg)
            2'h0: sda_rel_next = 1'b0;
            2'h1: scl_rel_next = 1'b1;
            2'h2: sda_rel_next = 1'b1;
            2'h3: lst_next = iws_pkg::IWS_L_DONE;
          endcase
        end
      end
      iws_pkg::IWS_L_DONE: begin
        sda_rel_next = 1'b1;
        dtgl_next    = ~dtgl_reg;
        lst_next     = iws_pkg::IWS_L_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      ctgl_s3     <= 1'b0;
      btgl_s3     <= 1'b0;
      lst_reg     <= iws_pkg::IWS_L_IDLE;
      lres_reg    <= iws_pkg::IWS_RES_OK;
      ph_reg      <= 2'h0;
      qcnt_reg    <= 4'h0;
      bit_reg     <= 3'h0;
      sh_reg      <= 8'h00;
      isaddr_reg  <= 1'b0;
      haddr_reg   <= 1'b0;
      nack_reg    <= 1'b0;
      rem1_reg    <= '0;
      rem2_reg    <= '0;
      scl_rel_reg <= 1'b1;
      sda_rel_reg <= 1'b1;
      dtgl_reg    <= 1'b0;
      breq_reg    <= 1'b0;
    end else if (en_s2) begin
      ctgl_s3     <= ctgl_s2;
      btgl_s3     <= btgl_s2;
      lst_reg     <= lst_next;
      lres_reg    <= lres_next;
      ph_reg      <= ph_next;
      qcnt_reg    <= qcnt_next;
      bit_reg     <= bit_next;
      sh_reg      <= sh_next;
      isaddr_reg  <= isaddr_next;
      haddr_reg   <= haddr_next;
      nack_reg    <= nack_next;
      rem1_reg    <= rem1_next;
      rem2_reg    <= rem2_next;
      scl_rel_reg <= scl_rel_next;
      sda_rel_reg <= sda_rel_next;
      dtgl_reg    <= dtgl_next;
      breq_reg    <= breq_next;
    end
  end

  // ==========================================================
  // assertions
  property p_start_then_addr;
    @(posedge link_clk) disable iff (!lrst_n)
    (en_s2 && lst_reg == iws_pkg::IWS_L_START && tick && ph_reg == 2'h3
     && haddr_reg) |=> (lst_reg == iws_pkg::IWS_L_BIT && isaddr_reg);
  endproperty
  a_start_then_addr: assert property (p_start_then_addr)
    else $error("address byte did not follow start");
  property p_dir_write;
    @(posedge link_clk) disable iff (!lrst_n)
    (en_s2 && lst_reg == iws_pkg::IWS_L_BIT && isaddr_reg && bit_reg == 3'h7
     && tick && ph_reg == 2'h0) |=> !sda_oe_n;
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction bit not driven as write");
  property p_addr_shift;
    @(posedge link_clk) disable iff (!lrst_n)
    (en_s2 && lst_reg == iws_pkg::IWS_L_START && tick && ph_reg == 2'h3
     && haddr_reg) |=> sh_reg == {$past(cmd_reg.slave_addr), 1'b0};
  endproperty
  a_addr_shift: assert property (p_addr_shift)
    else $error("address byte not formed by left shift");
  property p_fetch_data;
    @(posedge link_clk) disable iff (!lrst_n)
    (en_s2 && lst_reg == iws_pkg::IWS_L_ACK && tick && ph_reg == 2'h3
     && !nack_reg && (rem1_reg != '0 || rem2_reg != '0))
    |=> lst_reg == iws_pkg::IWS_L_FETCH && breq_reg != $past(breq_reg);
  endproperty
  a_fetch_data: assert property (p_fetch_data)
    else $error("pending data byte not fetched");
  property p_first_before_second;
    @(posedge link_clk) disable iff (!lrst_n)
    (en_s2 && lst_reg == iws_pkg::IWS_L_FETCH && back_edge && rem1_reg != '0)
    |=> rem1_reg == dec($past(rem1_reg)) && rem2_reg == $past(rem2_reg);
  endproperty
  a_first_before_second: assert property (p_first_before_second)
    else $error("second block consumed before first block");
  property p_no_data_stop;
    @(posedge link_clk) disable iff (!lrst_n)
    (en_s2 && lst_reg == iws_pkg::IWS_L_ACK && tick && ph_reg == 2'h3
     && rem1_reg == '0 && rem2_reg == '0)
    |=> lst_reg == iws_pkg::IWS_L_STOP;
  endproperty
  a_no_data_stop: assert property (p_no_data_stop)
    else $error("stop not issued after last byte");
  property p_bare_start_stop;
    @(posedge link_clk) disable iff (!lrst_n)
    (en_s2 && lst_reg == iws_pkg::IWS_L_START && tick && ph_reg == 2'h3
     && !haddr_reg) |=> lst_reg == iws_pkg::IWS_L_STOP;
  endproperty
  a_bare_start_stop: assert property (p_bare_start_stop)
    else $error("start without address not followed by stop");
  property p_stop_release;
    @(posedge link_clk) disable iff (!lrst_n)
    (en_s2 && lst_reg == iws_pkg::IWS_L_STOP && tick && ph_reg == 2'h2)
    |=> sda_oe_n && scl_oe_n ##1 (!en_s2 || (sda_oe_n && scl_oe_n));
  endproperty
  a_stop_release: assert property (p_stop_release)
    else $error("bus not released by stop");
  property p_invalid_reject;
    @(posedge clock) disable iff (!rst_n)
    (req_valid && req_ready && !pattern_ok(req))
    |=> resp.done && resp.result == iws_pkg::IWS_RES_INVALID && !busy;
  endproperty
  a_invalid_reject: assert property (p_invalid_reject)
    else $error("invalid pattern not rejected");
  property p_done_pulse;
    @(posedge clock) disable iff (!rst_n)
    resp.done && clk_en && !(req_valid && req_ready) |=> !resp.done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("completion longer than one cycle");
  c_full: cover property (@(posedge link_clk) disable iff (!lrst_n)
    lst_reg == iws_pkg::IWS_L_FETCH && rem1_reg != '0 && rem2_reg != '0);
  c_arb: cover property (@(posedge clock) disable iff (!rst_n)
    resp.done && resp.result == iws_pkg::IWS_RES_ARB_LOST);
  c_bare: cover property (@(posedge link_clk) disable iff (!lrst_n)
    lst_reg == iws_pkg::IWS_L_STOP && !haddr_reg);
endmodule
`default_nettype wire

// *** bench/iws_slave.sv ***
// i2c slave partner: logs bytes and framing, acks or nacks each byte
// assumes open-drain lines resolved with pull-ups in the bench
`timescale 1ns/1ps
`default_nettype none
module iws_slave (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic nack_all,
  output logic      sda_low
);
  int         starts = 0;
  int         stops = 0;
  int         nbytes = 0;
  int         nb = 0;
  logic       act = 1'b0;
  logic [7:0] sh;
  logic [7:0] got [0:15];
  initial sda_low = 1'b0;
  // ==========
  // framing
  always @(negedge sda) begin
    if (scl) begin
      starts++;
      nb = 0;
      act = 1'b1;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      stops++;
      act = 1'b0;
    end
  end
  // ==========
  // bits msb first, then ack slot
  always @(posedge scl) begin
    if (act && nb < 8) begin
      sh = {sh[6:0], sda};
      nb++;
      if (nb == 8 && nbytes < 16) begin
        got[nbytes] = sh;
        nbytes++;
      end
    end
  end
  always @(negedge scl) begin
    if (nb == 8) begin
      sda_low = ~nack_all;
      nb = 9;
    end else if (nb == 9) begin
      sda_low = 1'b0;
      nb = 0;
    end
  end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the i2c master write sequencer
// assumes iws_pkg compiled first; pull-ups on both bus lines
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic               clock;
  logic               rst_n;
  logic               clk_en;
  logic               link_clk;
  iws_pkg::iws_req_t  req;
  logic               req_valid;
  logic               req_ready;
  logic [7:0]         wr_data;
  logic               wr_valid;
  logic               wr_ready;
  iws_pkg::iws_resp_t resp;
  logic               busy;
  logic               scl_o;
  logic               scl_oe_n;
  logic               sda_o;
  logic               sda_oe_n;
  logic               slv_low;
  logic               ext_low;
  logic               nack_all;
  wire logic          scl;
  wire logic          sda;
  int                 mismatches;
  int                 check_count;
  int                 cycles;
  assign scl = scl_oe_n ? 1'b1 : scl_o;
  assign sda = (sda_oe_n ? 1'b1 : sda_o) & ~slv_low & ~ext_low;
  iws_seq i_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .resp(resp), .busy(busy),
    .link_clk(link_clk), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
  iws_slave i_slave (.scl(scl), .sda(sda), .nack_all(nack_all),
    .sda_low(slv_low));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      give_verdict();
    end
  end
  // ==========
  // compares and drivers
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic feed(input int first, input int cnt);
    for (int i = first; i < first + cnt; i++) begin
      wr_data = 8'h80 + i[7:0];
      wr_valid = 1'b1;
      while (wr_ready !== 1'b1) begin @(posedge clock); #1; end
      @(posedge clock);
      #1;
    end
    wr_valid = 1'b0;
  endtask
  task automatic run_req(input logic ap, input logic [6:0] a,
      input logic [31:0] c1, input logic [31:0] c2, input int fst,
      input int nf, input logic [2:0] exp);
    int n;
    i_slave.starts = 0;
    i_slave.stops = 0;
    i_slave.nbytes = 0;
    req = {ap, a, c1, c2};
    req_valid = 1'b1;
    while (req_ready !== 1'b1) begin @(posedge clock); #1; end
    @(posedge clock);
    #1;
    req_valid = 1'b0;
    fork feed(fst, nf); join_none
    n = 0;
    while (resp.done !== 1'b1 && n < 20000) begin @(posedge clock); #1; n++; end
    if (n == 20000) begin
      mismatches++;
      give_verdict();
    end
    chk_val(resp.result, exp);
    chk_val({busy, scl_oe_n, sda_oe_n}, 3'h3);
  endtask
  task automatic chk_frame(input logic ap, input logic [6:0] a, input int nd);
    chk_val(i_slave.starts, 1);
    chk_val(i_slave.stops, 1);
    chk_val(i_slave.nbytes, ap + nd);
    if (ap) chk_val(i_slave.got[0], {a, 1'b0});
    for (int i = 0; i < nd; i++) chk_val(i_slave.got[ap + i], 8'h80 + i);
  endtask
  // ==========
  // scenarios
  task automatic t_full;
    feed(0, 2);
    chk_val(wr_ready, 1'b0);
    run_req(1'b1, 7'h50, 1, 3, 2, 2, iws_pkg::IWS_RES_OK);
    chk_frame(1'b1, 7'h50, 4);
  endtask
  task automatic t_second;
    fork begin
      repeat (300) @(posedge clock);
      #1;
      clk_en = 1'b0;
      repeat (200) @(posedge clock);
      #1;
      chk_val(busy, 1'b1);
      clk_en = 1'b1;
    end join_none
    run_req(1'b1, 7'h3A, 0, 2, 0, 2, iws_pkg::IWS_RES_OK);
    chk_frame(1'b1, 7'h3A, 2);
  endtask
  task automatic t_addr;
    nack_all = 1'b1;
    run_req(1'b1, 7'h7F, 0, 0, 0, 0, iws_pkg::IWS_RES_NACK);
    chk_frame(1'b1, 7'h7F, 0);
    nack_all = 1'b0;
    run_req(1'b1, 7'h2B, 0, 0, 0, 0, iws_pkg::IWS_RES_OK);
    chk_frame(1'b1, 7'h2B, 0);
  endtask
  task automatic t_bare;
    run_req(1'b0, 7'h00, 0, 0, 0, 0, iws_pkg::IWS_RES_OK);
    chk_frame(1'b0, 7'h00, 0);
  endtask
  task automatic t_invalid;
    run_req(1'b0, 7'h11, 0, 1, 0, 0, iws_pkg::IWS_RES_INVALID);
    chk_val(i_slave.starts, 0);
    run_req(1'b1, 7'h11, 1, 0, 0, 0, iws_pkg::IWS_RES_INVALID);
    chk_val(i_slave.starts, 0);
  endtask
  task automatic t_faults;
    ext_low = 1'b1;
    repeat (20) @(posedge clock);
    #1;
    run_req(1'b1, 7'h50, 0, 0, 0, 0, iws_pkg::IWS_RES_BUS_BUSY);
    chk_val(i_slave.starts, 0);
    ext_low = 1'b0;
    repeat (20) @(posedge clock);
    #1;
    i_slave.starts = 0;
    fork begin wait (i_slave.starts == 1); ext_low = 1'b1; end join_none
    run_req(1'b1, 7'h50, 0, 0, 0, 0, iws_pkg::IWS_RES_ARB_LOST);
    ext_low = 1'b0;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    {rst_n, req_valid, wr_valid, ext_low, nack_all} = 5'h00;
    clk_en = 1'b1;
    req = '0;
    wr_data = 8'h00;
    mismatches = 0;
    check_count = 0;
    cycles = 0;
    repeat (5) @(posedge clock);
    #1;
    chk_val({busy, resp.done, scl_oe_n, sda_oe_n}, 4'h3);
    rst_n = 1'b1;
    repeat (10) @(posedge clock);
    #1;
    t_full();
    t_second();
    t_addr();
    t_bare();
    t_invalid();
    t_faults();
    give_verdict();
  end
endmodule
`default_nettype wire
